// >>> core/rx_stat_pkg.sv
// Purpose: Shared constants and carrier types for the receive statistics block.
// Assumes: One receive-side clock; frame bytes arrive least significant lane first.
// Notes: Bus offsets are byte addresses of 32-bit words.
package rx_stat_pkg;
  // Avalon register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MAX_LEN = 8'h04;
  localparam logic [7:0] OFS_STATION_LO = 8'h08;
  localparam logic [7:0] OFS_STATION_HI = 8'h0C;
  localparam logic [7:0] OFS_FRAME_COUNT = 8'h10;
  localparam logic [7:0] OFS_LAST_VECTOR = 8'h14;
  // Control register fields and reset values
  localparam int CTRL_VLAN_EN = 0;
  localparam int CTRL_JUMBO_EN = 1;
  localparam int CTRL_PAUSE_EN = 2;
  localparam int CTRL_PFC_EN = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [14:0] MAX_LEN_RST = 15'h05EE;
  localparam logic [47:0] STATION_RST = 48'h000000000000;
  // Statistics word bit positions
  localparam int VB_PFC = 30;
  localparam int VB_LEN_MISMATCH = 29;
  localparam int VB_BAD_OPCODE = 28;
  localparam int VB_PAUSE = 27;
  localparam int VB_BYTES_LO = 23;
  localparam int VB_VLAN = 22;
  localparam int VB_OVERSIZE = 21;
  localparam int VB_CONTROL = 20;
  localparam int VB_LEN_LO = 5;
  localparam int VB_MULTICAST = 4;
  localparam int VB_BROADCAST = 3;
  localparam int VB_FCS = 2;
  localparam int VB_BAD = 1;
  localparam int VB_GOOD = 0;
  // Frame format constants
  localparam int HDR_BYTES = 18;
  localparam logic [14:0] LEN_SAT = 15'h7FFF;
  localparam logic [14:0] MIN_FRAME = 15'h0040;
  localparam logic [14:0] FRAME_OVERHEAD = 15'h0012;
  localparam logic [15:0] LEN_TYPE_MAX = 16'h05DC;
  localparam logic [15:0] PAD_DATA = 16'h002E;
  localparam logic [15:0] TYPE_VLAN = 16'h8100;
  localparam logic [15:0] TYPE_MAC_CTRL = 16'h8808;
  localparam logic [15:0] OP_PAUSE = 16'h0001;
  localparam logic [15:0] OP_PFC = 16'h0101;
  localparam logic [47:0] DA_MAC_CTRL = 48'h0180C2000001;
  localparam logic [47:0] DA_BCAST = 48'hFFFFFFFFFFFF;

  // One receive beat, lane 0 holds the earliest byte
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] keep;
    logic valid;
    logic last;
    logic fcs_bad;
    logic code_err;
  } beat_t;

  // Avalon-MM slave request
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } av_req_t;
endpackage : rx_stat_pkg

// >>> core/rx_stat_vector.sv
// Purpose: Builds the per-frame receive statistics word and its strobe.
// Assumes: Receive beats come from logic on the same clock; no back-pressure.
// Notes: The stream is forwarded one cycle late so the strobe aligns to tlast at 64 bits; at 32 bits it trails tlast by one cycle.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module rx_stat_vector #(
  parameter int DATA_BYTES = 8,
  parameter bit PFC_BUILT = 1'b0,
  parameter int VEC_W = PFC_BUILT ? 31 : 30
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire rx_stat_pkg::beat_t rx_in,
  output rx_stat_pkg::beat_t rx_out,
  output logic [VEC_W-1:0] stat_vector,
  output logic stat_valid,
  input wire rx_stat_pkg::av_req_t av_req,
  output logic av_waitrequest,
  output logic [31:0] av_readdata
);
  import rx_stat_pkg::*;

  // Refuse widths the lane logic cannot serve
  initial begin
    if (DATA_BYTES != 4 && DATA_BYTES != 8) begin
      $error("DATA_BYTES must be 4 or 8");
    end
    if (VEC_W != (PFC_BUILT ? 31 : 30)) begin
      $error("VEC_W must follow PFC_BUILT");
    end
  end

  // Register file state
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [14:0] max_len_r, max_len_nxt;
  logic [47:0] station_r, station_nxt;
  logic [31:0] frame_count_r, frame_count_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // Parser state
  logic [14:0] pos_r, pos_nxt;
  logic [7:0] hdr_r [HDR_BYTES];
  logic [7:0] hdr_nxt [HDR_BYTES];
  logic err_r, err_nxt;

  // Output state
  beat_t out_r, out_nxt;
  logic [30:0] vec_r, vec_nxt;
  logic [30:0] pend_r, pend_nxt;
  logic pend_v_r, pend_v_nxt;
  logic valid_r, valid_nxt;
  logic [3:0] bytes_r, bytes_nxt;

  // Per-lane enables and absolute byte positions
  logic [DATA_BYTES-1:0] lane_on;
  logic [14:0] lane_pos [DATA_BYTES];
  genvar g;
  generate
    for (g = 0; g < DATA_BYTES; g++) begin : g_lane
      assign lane_on[g] = rx_in.valid & rx_in.keep[g];
      assign lane_pos[g] = pos_r + 15'(g);
    end
  endgenerate

  // Frame decode from the header as it stands after this beat
  logic [3:0] beat_cnt;
  logic [15:0] len_sum;
  logic [14:0] len_now;
  logic [47:0] da;
  logic [15:0] type_f;
  logic [15:0] opcode;
  logic fcs_err, oversize, undersize, bad;
  logic is_ctrl, is_vlan, is_bcast, is_mcast;
  logic mismatch, pause_ok, pfc_ok, bad_op;
  logic [14:0] data_len;
  logic [30:0] frame_word;

  // Parser next state: position, header bytes, sticky error
  always_comb begin
    beat_cnt = 4'h0;
    for (int i = 0; i < DATA_BYTES; i++) begin
      beat_cnt = beat_cnt + {3'h0, lane_on[i]};
    end
    len_sum = {1'b0, pos_r} + {12'h000, beat_cnt};
    len_now = len_sum[15] ? LEN_SAT : len_sum[14:0];
    for (int j = 0; j < HDR_BYTES; j++) begin
      hdr_nxt[j] = hdr_r[j];
    end
    for (int i = 0; i < DATA_BYTES; i++) begin
      if (lane_on[i] && pos_r < 15'(HDR_BYTES) && lane_pos[i] < 15'(HDR_BYTES)) begin
        hdr_nxt[lane_pos[i][4:0]] = rx_in.data[8*i +: 8]; // Saturated count never wraps back
      end
    end
    pos_nxt = pos_r;
    err_nxt = err_r;
    if (rx_in.valid) begin
      pos_nxt = rx_in.last ? 15'h0000 : len_now;
      err_nxt = rx_in.last ? 1'b0 : (err_r | rx_in.code_err);
    end
  end

  // Field extraction and per-frame flags
  always_comb begin
    da = {hdr_nxt[0], hdr_nxt[1], hdr_nxt[2], hdr_nxt[3], hdr_nxt[4], hdr_nxt[5]};
    type_f = {hdr_nxt[12], hdr_nxt[13]};
    opcode = {hdr_nxt[14], hdr_nxt[15]};
    fcs_err = rx_in.fcs_bad | rx_in.code_err | err_r;
    oversize = !ctrl_r[CTRL_JUMBO_EN] && (len_now > max_len_r);
    undersize = len_now < MIN_FRAME;
    bad = fcs_err | oversize | undersize;
    is_ctrl = type_f == TYPE_MAC_CTRL;
    is_vlan = (type_f == TYPE_VLAN) && ctrl_r[CTRL_VLAN_EN];
    is_bcast = da == DA_BCAST;
    is_mcast = da[40] && !is_bcast;
    data_len = (len_now > FRAME_OVERHEAD) ? (len_now - FRAME_OVERHEAD) : 15'h0000;
    // Only length values are checked; tagged and typed frames never are
    mismatch = 1'b0;
    if (type_f <= LEN_TYPE_MAX) begin
      if (type_f < PAD_DATA) begin
        mismatch = len_now != MIN_FRAME;
      end else begin
        mismatch = {1'b0, data_len} != type_f;
      end
    end
    pause_ok = !bad && is_ctrl && opcode == OP_PAUSE && ctrl_r[CTRL_PAUSE_EN]
      && (da == DA_MAC_CTRL || da == station_r);
    bad_op = !bad && is_ctrl && opcode != OP_PAUSE;
    pfc_ok = PFC_BUILT && ctrl_r[CTRL_PFC_EN] && !bad && is_ctrl
      && opcode == OP_PFC && da == DA_MAC_CTRL;
    frame_word = 31'h00000000;
    frame_word[VB_PFC] = pfc_ok;
    frame_word[VB_LEN_MISMATCH] = mismatch;
    frame_word[VB_BAD_OPCODE] = bad_op;
    frame_word[VB_PAUSE] = pause_ok;
    frame_word[VB_VLAN] = is_vlan;
    frame_word[VB_OVERSIZE] = oversize;
    frame_word[VB_CONTROL] = is_ctrl;
    frame_word[VB_LEN_LO +: 15] = len_now;
    frame_word[VB_MULTICAST] = is_mcast;
    frame_word[VB_BROADCAST] = is_bcast;
    frame_word[VB_FCS] = fcs_err;
    frame_word[VB_BAD] = bad;
    frame_word[VB_GOOD] = !bad;
  end

  // Parser registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pos_r <= 15'h0000;
      err_r <= 1'b0;
      for (int j = 0; j < HDR_BYTES; j++) begin
        hdr_r[j] <= 8'h00;
      end
    end else if (clk_en) begin
      pos_r <= pos_nxt;
      err_r <= err_nxt;
      for (int j = 0; j < HDR_BYTES; j++) begin
        hdr_r[j] <= hdr_nxt[j];
      end
    end
  end

  // Output next state: forwarded beat, strobe and statistics word
  always_comb begin
    out_nxt = rx_in;
    bytes_nxt = beat_cnt;
    pend_nxt = pend_r;
    pend_v_nxt = 1'b0;
    vec_nxt = vec_r;
    valid_nxt = 1'b0;
    frame_count_nxt = frame_count_r;
    if (DATA_BYTES == 8) begin
      // Strobe shares the cycle of the forwarded tlast
      if (rx_in.valid && rx_in.last) begin
        vec_nxt = frame_word;
        valid_nxt = 1'b1;
        frame_count_nxt = frame_count_r + 32'h00000001;
      end
    end else begin
      // Hold one more stage so the strobe trails the forwarded tlast
      if (rx_in.valid && rx_in.last) begin
        pend_nxt = frame_word;
        pend_v_nxt = 1'b1;
      end
      if (pend_v_r) begin
        vec_nxt = pend_r;
        valid_nxt = 1'b1;
        frame_count_nxt = frame_count_r + 32'h00000001;
      end
    end
    // Byte count rides in every cycle, outside the strobe
    vec_nxt[VB_BYTES_LO +: 4] = bytes_r;
  end

  // Output registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_r <= '0;
      bytes_r <= 4'h0;
      pend_r <= 31'h00000000;
      pend_v_r <= 1'b0;
      vec_r <= 31'h00000000;
      valid_r <= 1'b0;
      frame_count_r <= 32'h00000000;
    end else if (clk_en) begin
      out_r <= out_nxt;
      bytes_r <= bytes_nxt;
      pend_r <= pend_nxt;
      pend_v_r <= pend_v_nxt;
      vec_r <= vec_nxt;
      valid_r <= valid_nxt;
      frame_count_r <= frame_count_nxt;
    end
  end

  // Avalon slave: waitrequest drops one cycle after a request appears
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  logic [31:0] wr_ctrl, wr_max, wr_lo, wr_hi;

  // Bus next state: handshake, register writes, read data
  always_comb begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    max_len_nxt = max_len_r;
    station_nxt = station_r;
    wr_ctrl = merge({28'h0000000, ctrl_r}, av_req.writedata, av_req.byteenable);
    wr_max = merge({17'h00000, max_len_r}, av_req.writedata, av_req.byteenable);
    wr_lo = merge(station_r[31:0], av_req.writedata, av_req.byteenable);
    wr_hi = merge({16'h0000, station_r[47:32]}, av_req.writedata, av_req.byteenable);
    if ((av_req.read || av_req.write) && wait_r) begin
      wait_nxt = 1'b0;
      rdata_nxt = 32'h00000000;
      if (av_req.read) begin
        case (av_req.address)
          OFS_CTRL: rdata_nxt = {28'h0000000, ctrl_r};
          OFS_MAX_LEN: rdata_nxt = {17'h00000, max_len_r};
          OFS_STATION_LO: rdata_nxt = station_r[31:0];
          OFS_STATION_HI: rdata_nxt = {16'h0000, station_r[47:32]};
          OFS_FRAME_COUNT: rdata_nxt = frame_count_r;
          OFS_LAST_VECTOR: rdata_nxt = {1'b0, vec_r};
          default: rdata_nxt = 32'h00000000;
        endcase
      end
    end
    // Writes land on the edge where waitrequest is seen low
    if (av_req.write && !wait_r) begin
      case (av_req.address)
        OFS_CTRL: ctrl_nxt = wr_ctrl[3:0];
        OFS_MAX_LEN: max_len_nxt = wr_max[14:0];
        OFS_STATION_LO: station_nxt[31:0] = wr_lo;
        OFS_STATION_HI: station_nxt[47:32] = wr_hi[15:0];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
      ctrl_r <= CTRL_RST;
      max_len_r <= MAX_LEN_RST;
      station_r <= STATION_RST;
    end else if (clk_en) begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      max_len_r <= max_len_nxt;
      station_r <= station_nxt;
    end
  end

  // Ports straight from flops
  assign rx_out = out_r;
  assign stat_vector = vec_r[VEC_W-1:0];
  assign stat_valid = valid_r;
  assign av_waitrequest = wait_r;
  assign av_readdata = rdata_r;
endmodule : rx_stat_vector

// >>> test/rx_stat_checker_asserts.sv
// Purpose: Concurrent checks on the receive statistics outputs.
// Assumes: Strobe timing follows DATA_BYTES; clk_en low freezes all checks.
// Notes: Bound into every rx_stat_vector instance; stream idles around clk_en low.
`timescale 1ns/1ps
module rx_stat_checker #(
  parameter int VEC_W = 30,
  parameter int DATA_BYTES = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire rx_stat_pkg::beat_t rx_in,
  input wire rx_stat_pkg::beat_t rx_out,
  input wire logic [VEC_W-1:0] stat_vector,
  input wire logic stat_valid
);
  import rx_stat_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst || !clk_en);
  // Strobe with the client tlast at 64 bits, one cycle after it at 32 bits
  AST_STROBE_TLAST: assert property (stat_valid |-> ((DATA_BYTES == 8) ?
    (rx_out.valid && rx_out.last) : $past(rx_out.valid && rx_out.last)))
    else $error("strobe without tlast");
  AST_TLAST_STROBE: assert property (((DATA_BYTES == 8) ?
    (rx_out.valid && rx_out.last) : $past(rx_out.valid && rx_out.last)) |-> stat_valid)
    else $error("tlast without strobe");
  AST_ONE_CYCLE: assert property (stat_valid |=> !stat_valid)
    else $error("strobe longer than one cycle");
  // Client stream is the input beat one cycle late
  AST_FORWARD: assert property (rx_out == $past(rx_in))
    else $error("forwarded beat wrong");
  // Flag word only moves on a strobe
  AST_HOLD: assert property (!stat_valid |->
    $stable({stat_vector[VEC_W-1:27], stat_vector[22:0]}))
    else $error("flags changed without strobe");
  // Byte count follows the used lanes of the input beat two cycles back
  AST_BYTES: assert property (stat_vector[26:23] == (
    $past(rx_in.valid, 2) ? 4'($countones($past(rx_in.keep, 2) & 8'((1 << DATA_BYTES) - 1)))
    : 4'h0))
    else $error("byte count wrong");
  AST_GOOD_BAD: assert property (stat_valid |->
    stat_vector[VB_GOOD] != stat_vector[VB_BAD])
    else $error("good and bad agree");
  AST_FCS_BAD: assert property (stat_valid && stat_vector[VB_FCS] |->
    stat_vector[VB_BAD])
    else $error("fcs error not bad");
  AST_ADDR_KIND: assert property (stat_valid |->
    !(stat_vector[VB_BROADCAST] && stat_vector[VB_MULTICAST]))
    else $error("broadcast also multicast");
  AST_PAUSE: assert property (stat_valid && stat_vector[VB_PAUSE] |->
    stat_vector[VB_CONTROL] && stat_vector[VB_GOOD] && !stat_vector[VB_BAD_OPCODE])
    else $error("pause flag inconsistent");
  AST_OVERSIZE: assert property (stat_valid && stat_vector[VB_OVERSIZE] |->
    stat_vector[VB_BAD])
    else $error("oversize frame not bad");
endmodule : rx_stat_checker

bind rx_stat_vector rx_stat_checker #(.VEC_W(VEC_W), .DATA_BYTES(DATA_BYTES))
  rx_stat_checker_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .rx_in(rx_in),
  .rx_out(rx_out), .stat_vector(stat_vector), .stat_valid(stat_valid));

// >>> test/rx_stat_client.sv
// Purpose: Client statistics consumer model.
// Assumes: Same receive clock as the block.
// Notes: Takes the word only while the strobe is high.
`timescale 1ns/1ps
module rx_stat_client (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [29:0] stat_vector,
  input wire logic stat_valid,
  output logic [29:0] cap,
  output int n_seen
);
  // Latch the flag word on each strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cap <= 30'h0;
      n_seen <= 0;
    end else if (stat_valid) begin
      cap <= stat_vector;
      n_seen <= n_seen + 1;
    end
  end
endmodule : rx_stat_client

// >>> test/rx_stat_vector_test.sv
// Purpose: Self-checking bench for the receive statistics word.
// Assumes: Main instance 64-bit without priority pause; a second is 32-bit with it.
// Notes: Expected flags are written per frame from its contents.
`timescale 1ns/1ps
module rx_stat_vector_test;
  import rx_stat_pkg::*;
  logic clock, sys_rst, clk_en, stat_valid, av_waitrequest;
  beat_t rx_in, rx_out;
  av_req_t av_req;
  logic [29:0] stat_vector, cap;
  logic [31:0] av_readdata, q;
  int n_seen, n_fail = 0, tests_run = 0, n_frames = 0;
  beat_t rx_in4, rx_out4;
  logic [30:0] stat_vector4;
  logic stat_valid4;
  rx_stat_vector rx_stat_vector_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .rx_in(rx_in), .rx_out(rx_out), .stat_vector(stat_vector), .stat_valid(stat_valid),
    .av_req(av_req), .av_waitrequest(av_waitrequest), .av_readdata(av_readdata));
  rx_stat_client rx_stat_client_inst (.clock(clock), .sys_rst(sys_rst),
    .stat_vector(stat_vector), .stat_valid(stat_valid), .cap(cap), .n_seen(n_seen));
  // 32-bit build with priority pause; shares the bus, answers come from the main instance
  rx_stat_vector #(.DATA_BYTES(4), .PFC_BUILT(1'b1), .VEC_W(31)) rx_stat_vector_n32_inst (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .rx_in(rx_in4), .rx_out(rx_out4),
    .stat_vector(stat_vector4), .stat_valid(stat_valid4), .av_req(av_req),
    .av_waitrequest(), .av_readdata());
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic final_report();
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    av_req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge clock);
      k++;
    end while (av_waitrequest !== 1'b0 && k < 20);
    q = av_readdata;
    if (av_waitrequest !== 1'b0) begin
      n_fail++;
      final_report();
    end
    av_req <= '0;
    @(posedge clock);
  endtask : bus
  // Sends one frame lane by lane and compares the captured flag word
  task automatic send_frame(input logic [47:0] da, input logic [15:0] ty, input logic [15:0] op,
    input int len, input logic fcs, input logic [29:0] exp);
    beat_t bt;
    logic [7:0] b;
    int i, n0, k, lc;
    bt = '0;
    n0 = n_seen;
    n_frames++;
    for (i = 0; i < len; i++) begin
      b = (i < 6) ? da[47-8*i -: 8] : (i == 12) ? ty[15:8] : (i == 13) ? ty[7:0] :
        (i == 14) ? op[15:8] : (i == 15) ? op[7:0] : 8'h00;
      bt.data[8*(i%8) +: 8] = b;
      bt.keep[i%8] = 1'b1;
      if (i % 8 == 7 || i == len - 1) begin
        bt.valid = 1'b1;
        bt.last = (i == len - 1);
        bt.fcs_bad = fcs && bt.last;
        rx_in <= bt;
        @(posedge clock);
        bt = '0;
      end
    end
    rx_in <= '0;
    for (k = 0; k < 8 && n_seen == n0; k++) @(posedge clock);
    if (n_seen == n0) begin
      n_fail++;
      final_report();
    end
    lc = (len > 32767) ? 32767 : len;
    check({2'h0, cap & 30'h387FFFFF}, {2'h0, exp | (30'(lc) << 5)});
  endtask : send_frame
  task automatic t_addr();
    send_frame(48'hFFFFFFFFFFFF, 16'h0800, 16'h0000, 64, 1'b0, 30'h9);
    send_frame(48'h01005E000001, 16'h0800, 16'h0000, 65, 1'b0, 30'h11);
    send_frame(48'h020000000001, 16'h0800, 16'h0000, 1518, 1'b0, 30'h1);
  endtask : t_addr
  task automatic t_err();
    send_frame(48'h020000000001, 16'h0800, 16'h0000, 64, 1'b1, 30'h6);
    send_frame(48'h020000000001, 16'h0800, 16'h0000, 60, 1'b0, 30'h2);
  endtask : t_err
  task automatic t_ctrl();
    bus(1'b1, OFS_STATION_LO, 32'h0C0D0E0F);
    bus(1'b1, OFS_STATION_HI, 32'h00000A0B);
    send_frame(DA_MAC_CTRL, TYPE_MAC_CTRL, OP_PAUSE, 64, 1'b0, 30'h00100011);
    bus(1'b1, OFS_CTRL, 32'h4);
    send_frame(DA_MAC_CTRL, TYPE_MAC_CTRL, OP_PAUSE, 64, 1'b0, 30'h08100011);
    send_frame(48'h0A0B0C0D0E0F, TYPE_MAC_CTRL, OP_PAUSE, 64, 1'b0, 30'h08100001);
    send_frame(DA_MAC_CTRL, TYPE_MAC_CTRL, 16'h0002, 64, 1'b0, 30'h10100011);
  endtask : t_ctrl
  task automatic t_len();
    send_frame(48'h020000000001, 16'h0010, 16'h0000, 64, 1'b0, 30'h1);
    send_frame(48'h020000000001, 16'h0010, 16'h0000, 70, 1'b0, 30'h20000001);
    send_frame(48'h020000000001, 16'h0064, 16'h0000, 118, 1'b0, 30'h1);
    send_frame(48'h020000000001, 16'h0064, 16'h0000, 119, 1'b0, 30'h20000001);
  endtask : t_len
  task automatic t_size();
    bus(1'b0, OFS_MAX_LEN, 32'h0);
    check(q, 32'h000005EE);
    bus(1'b1, OFS_MAX_LEN, 32'h64);
    send_frame(48'h020000000001, 16'h0800, 16'h0000, 101, 1'b0, 30'h00200002);
    bus(1'b1, OFS_CTRL, 32'h2);
    send_frame(48'h020000000001, 16'h0800, 16'h0000, 32770, 1'b0, 30'h1);
    bus(1'b1, OFS_CTRL, 32'h3);
    send_frame(48'h020000000001, TYPE_VLAN, 16'h0000, 70, 1'b0, 30'h00400001);
    bus(1'b0, OFS_LAST_VECTOR, 32'h0);
    check(q & 32'h387FFFFF, 32'h004008C1);
    bus(1'b0, 8'h40, 32'h0);
    check(q, 32'h0);
    // Request raised while frozen must wait for clk_en
    clk_en <= 1'b0;
    fork
      bus(1'b0, OFS_FRAME_COUNT, 32'h0);
      begin
        repeat (2) @(posedge clock);
        check({31'h0, av_waitrequest}, 32'h00000001);
        clk_en <= 1'b1;
      end
    join
    check(q, 32'(n_frames));
  endtask : t_size
  // 32-bit build: strobe trails tlast by one cycle and carries the priority flag
  task automatic t_narrow();
    beat_t bt;
    logic [47:0] da;
    int i;
    bus(1'b1, OFS_CTRL, 32'h8);
    da = DA_MAC_CTRL;
    bt = '0;
    for (i = 0; i < 64; i++) begin
      bt.data[8*(i%4) +: 8] = (i < 6) ? da[47-8*i -: 8] :
        (i == 12) ? TYPE_MAC_CTRL[15:8] : (i == 13) ? TYPE_MAC_CTRL[7:0] :
        (i == 14) ? OP_PFC[15:8] : (i == 15) ? OP_PFC[7:0] : 8'h00;
      bt.keep[i%4] = 1'b1;
      if (i % 4 == 3) begin
        bt.valid = 1'b1;
        bt.last = (i == 63);
        rx_in4 <= bt;
        @(posedge clock);
        bt = '0;
      end
    end
    rx_in4 <= '0;
    @(posedge clock);
    check({31'h0, rx_out4.last}, 32'h00000001);
    check({31'h0, stat_valid4}, 32'h00000000);
    @(posedge clock);
    check({31'h0, stat_valid4}, 32'h00000001);
    check({1'b0, stat_vector4 & 31'h787FFFFF}, 32'h50100811);
  endtask : t_narrow
  // Reset, then each scenario in turn
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    rx_in = '0;
    rx_in4 = '0;
    av_req = '0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_addr();
    t_err();
    t_ctrl();
    t_len();
    t_size();
    t_narrow();
    final_report();
  end
endmodule : rx_stat_vector_test
